// *** hdl/spv_pkg.sv ***
// Constants, command codes, memory map and field layout of the serial program/verify engine.
// Assumes one 40 MHz clock domain; programmer clock and data arrive asynchronously on pins.
package spv_pkg;
	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int CMD_BITS = 6;
	localparam int FRAME_CLOCKS = 16;
	localparam int WORD_BITS = 14;
	localparam int DATA_MEM_BITS = 8;
	localparam logic [4:0] DATA_FIRST_EDGE = 5'h02;
	localparam logic [4:0] DATA_LAST_EDGE = 5'h0f;
	// ----------------------------------------
	// Command codes (low four bits; upper two only matter for the begin commands and the 1, 7 clear sequence)
	// ----------------------------------------
	localparam logic [3:0] CMD_LOAD_CONFIG = 4'h0;
	localparam logic [3:0] CMD_LOAD_PROG = 4'h2;
	localparam logic [3:0] CMD_READ_PROG = 4'h4;
	localparam logic [3:0] CMD_INCREMENT = 4'h6;
	localparam logic [3:0] CMD_BEGIN = 4'h8;
	localparam logic [3:0] CMD_LOAD_DATA = 4'h3;
	localparam logic [3:0] CMD_READ_DATA = 4'h5;
	localparam logic [3:0] CMD_BULK_PROG = 4'h9;
	localparam logic [3:0] CMD_BULK_DATA = 4'hb;
	localparam logic [1:0] BEGIN_ERASE_HI = 2'h0;
	localparam logic [1:0] BEGIN_ONLY_HI = 2'h1;
	// ----------------------------------------
	// Memory map
	// ----------------------------------------
	localparam int PC_BITS = 14;
	localparam logic [13:0] CONFIG_BASE = 14'h2000;
	localparam logic [13:0] DEVICE_IDENTITY_ADDR = 14'h2006;
	localparam logic [13:0] DEVICE_CONFIG_ADDR = 14'h2007;
	localparam int CONFIG_SLOTS = 16;
	localparam logic [13:0] ERASED_WORD = 14'h3fff;
	localparam logic [13:0] ZERO_WORD = 14'h0000;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// ----------------------------------------
	// Configuration word fields
	// ----------------------------------------
	localparam logic [13:0] CP_MASK = 14'h3f70;
	localparam logic [13:0] CP_MASK_ROM = 14'h3f70;
	localparam int DP_BIT = 7;
	localparam int PWRT_BIT = 3;
	localparam int WDT_BIT = 2;
	localparam int OSC_LSB = 0;
	localparam logic [1:0] OSC_RC = 2'h3;
	localparam logic [1:0] OSC_HS = 2'h2;
	localparam logic [1:0] OSC_XT = 2'h1;
	localparam logic [1:0] OSC_LP = 2'h0;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int ERASE_TIME_US = 4000;
	localparam int WRITE_TIME_US = 4000;
	localparam int BULK_TIME_US = 10000;

	typedef struct packed {
		logic [1:0] osc;
		logic wdt_en;
		logic pwrt_en_n;
		logic code_protected;
		logic data_protected;
	} config_view_s;

	typedef enum logic [4:0] {
		ST_CMD = 5'b00001,
		ST_GAP = 5'b00010,
		ST_FRAME = 5'b00100,
		ST_BUSY = 5'b01000,
		ST_IDLE = 5'b10000
	} state_e;
endpackage

// *** hdl/spv_mem.sv ***
// Single-port word memory with registered read data.
// Assumes synchronous write and read on the same clock; no reset of contents.
`timescale 1ns/100ps
module spv_mem #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 1024,
	parameter int AW = 10
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	output logic [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] store [DEPTH];

	initial begin
		if (DEPTH > (1 << AW)) begin
			$error("depth exceeds address space");
		end
	end

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			store[addr_i] <= wdata_i;
		end
		rdata_o <= store[addr_i];
	end
endmodule

// *** hdl/serial_program_verify_engine.sv ***
// Serial program/verify command engine: command decode, frames, memories, protection.
// Assumes the programmer makes prog_clock_pin and prog_data_pin; both are asynchronous pins.
//
// What this block does
// - Six-bit commands, LSB first, latched on fall
// - Data frames: start, 14 bits LSB first, stop
// - Decode the documented command codes
// - Load configuration jumps counter into config space
// - Read drives data from edge 2 to 16
// - Data memory read: only 8 valid bits
// - Increment advances counter, no frame follows
// - Erase-program erases then writes addressed word
// - Program-only writes without erase, newer variant
// - Bulk erase arms next begin for whole memory
// - Config-space bulk erase spares configuration word
// - Bulk erase ignored while code protected, newer variant
// - Bits 1-0 select oscillator
// - Bit 2 watchdog, bit 3 power-up timer
// - Code-protect bits all zero means protected
// - Protected program memory reads zeros
// - Protection blocks program and data writes
// - ROM variant: protected data memory reads ones
// - Read-only identity word at 2006h, newer variant
// - Commands 1, 7 then begin clear protection
`timescale 1ns/100ps
module serial_program_verify_engine #(
	parameter bit NEWER_VARIANT = 1'b1,
	parameter bit ROM_VARIANT = 1'b0,
	parameter int PROG_DEPTH = 1024,
	parameter int PROG_AW = 10,
	parameter int DATA_DEPTH = 64,
	parameter int DATA_AW = 6,
	parameter logic [8:0] DEVICE_CODE = 9'h0a5, // Arbitrary value
	parameter logic [4:0] REVISION_CODE = 5'h01, // Arbitrary value
	parameter int ERASE_WRITE_CYCLES = spv_pkg::CLK_MHZ
		* (spv_pkg::ERASE_TIME_US + spv_pkg::WRITE_TIME_US),
	parameter int WRITE_CYCLES = spv_pkg::CLK_MHZ * spv_pkg::WRITE_TIME_US,
	parameter int BULK_CYCLES = spv_pkg::CLK_MHZ * spv_pkg::BULK_TIME_US
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic high_voltage_mode_select_i,
	input wire logic prog_clock_pin_i,
	input wire logic prog_data_pin_i,
	output logic prog_data_pin_o,
	output logic prog_data_pin_oe_o,
	output logic busy_o,
	output logic [13:0] device_config_word_o,
	output spv_pkg::config_view_s config_view_o
);
	// ----------------------------------------
	// Checks and synchronisers
	// ----------------------------------------
	// The wipe walks every program word, so the bulk timer must outlast it
	initial begin
		if (PROG_AW > spv_pkg::PC_BITS - 1 || DATA_AW > 8 || BULK_CYCLES <= PROG_DEPTH
			|| WRITE_CYCLES < 2 || ERASE_WRITE_CYCLES < 2 || DATA_DEPTH > PROG_DEPTH) begin
			$error("unsupported parameters");
		end
	end

	logic [1:0] clk_sync_reg;
	logic [1:0] dat_sync_reg;
	logic [1:0] hv_sync_reg;
	logic clk_prev_reg;
	always_ff @(posedge clk_i) begin
		clk_sync_reg <= {clk_sync_reg[0], prog_clock_pin_i};
		dat_sync_reg <= {dat_sync_reg[0], prog_data_pin_i};
		hv_sync_reg <= {hv_sync_reg[0], high_voltage_mode_select_i};
		clk_prev_reg <= clk_sync_reg[1];
	end
	wire rise = clk_sync_reg[1] & ~clk_prev_reg;
	wire fall = ~clk_sync_reg[1] & clk_prev_reg;
	wire din = dat_sync_reg[1];
	// Leaving the mode resets the engine; the counter can only return to user space this way
	wire mode_on = hv_sync_reg[1];

	// ----------------------------------------
	// State
	// ----------------------------------------
	spv_pkg::state_e state_reg, state_next;
	logic [2:0] cmd_cnt_reg;
	logic [5:0] cmd_reg;
	logic [4:0] edge_cnt_reg;
	logic [15:0] shift_reg;
	logic [13:0] pc_reg;
	logic [13:0] latch_reg;
	logic [13:0] config_reg;
	logic [13:0] id_loc_reg [4];
	logic bulk_prog_reg;
	logic bulk_data_reg;
	logic toggle1_reg;
	logic clear_armed_reg;
	logic [31:0] timer_reg;
	logic [PROG_AW:0] wipe_reg;
	logic wiping_reg;
	logic wipe_prog_reg;
	logic wipe_data_reg;
	logic pend_reg;
	logic pend_data_reg;
	// Which memory the last load frame aimed at
	logic load_data_reg;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic is_cmd(input logic [5:0] c, input logic [3:0] code);
		is_cmd = (c[3:0] == code);
	endfunction

	wire [5:0] cmd_full = {din, cmd_reg[5:1]};
	wire last_cmd_bit = (state_reg == spv_pkg::ST_CMD) && fall
		&& (cmd_cnt_reg == 3'(spv_pkg::CMD_BITS - 1));
	wire cmd_has_frame = is_cmd(cmd_full, spv_pkg::CMD_LOAD_CONFIG)
		|| is_cmd(cmd_full, spv_pkg::CMD_LOAD_PROG) || is_cmd(cmd_full, spv_pkg::CMD_READ_PROG)
		|| is_cmd(cmd_full, spv_pkg::CMD_LOAD_DATA)
		|| is_cmd(cmd_full, spv_pkg::CMD_READ_DATA);
	wire is_load = is_cmd(cmd_full, spv_pkg::CMD_LOAD_CONFIG)
		|| is_cmd(cmd_full, spv_pkg::CMD_LOAD_PROG) || is_cmd(cmd_full, spv_pkg::CMD_LOAD_DATA);
	wire begin_erase = is_cmd(cmd_full, spv_pkg::CMD_BEGIN)
		&& (cmd_full[5:4] == spv_pkg::BEGIN_ERASE_HI);
	wire begin_only = NEWER_VARIANT && is_cmd(cmd_full, spv_pkg::CMD_BEGIN)
		&& (cmd_full[5:4] == spv_pkg::BEGIN_ONLY_HI);
	wire is_read = is_cmd(cmd_reg, spv_pkg::CMD_READ_PROG) || is_cmd(cmd_reg, spv_pkg::CMD_READ_DATA);
	wire frame_end = (state_reg == spv_pkg::ST_FRAME) && fall
		&& (edge_cnt_reg == 5'(spv_pkg::FRAME_CLOCKS));

	wire protected_cp = ((config_reg & spv_pkg::CP_MASK) == spv_pkg::ZERO_WORD);
	wire protected_dp = ROM_VARIANT ? ~config_reg[spv_pkg::DP_BIT] : protected_cp;
	// Sequencer and wipe start share this, so a refused bulk never leaves a stale busy
	wire bulk_refused = NEWER_VARIANT && protected_cp && !clear_armed_reg;
	wire in_config = pc_reg[spv_pkg::PC_BITS-1];
	wire [3:0] cfg_slot = pc_reg[3:0];

	// ----------------------------------------
	// Memories
	// ----------------------------------------
	logic prog_we, data_we;
	logic [13:0] prog_rdata;
	logic [7:0] data_rdata;
	logic [PROG_AW-1:0] prog_addr;
	logic [DATA_AW-1:0] data_addr;
	assign prog_addr = wiping_reg ? wipe_reg[PROG_AW-1:0] : pc_reg[PROG_AW-1:0];
	assign data_addr = wiping_reg ? wipe_reg[DATA_AW-1:0] : pc_reg[DATA_AW-1:0];
	assign prog_we = (wiping_reg && wipe_prog_reg)
		|| (pend_reg && !pend_data_reg && !in_config && !protected_cp);
	assign data_we = (wiping_reg && wipe_data_reg && wipe_reg < (PROG_AW+1)'(DATA_DEPTH))
		|| (pend_reg && pend_data_reg && !protected_dp && !ROM_VARIANT);
	wire [13:0] prog_wdata = wiping_reg ? spv_pkg::ERASED_WORD : latch_reg;
	wire [7:0] data_wdata = wiping_reg ? spv_pkg::ERASED_BYTE
		: latch_reg[spv_pkg::DATA_MEM_BITS-1:0];

	spv_mem #(.WIDTH(14), .DEPTH(PROG_DEPTH), .AW(PROG_AW)) u_prog (
		.clk_i(clk_i), .we_i(prog_we), .addr_i(prog_addr), .wdata_i(prog_wdata),
		.rdata_o(prog_rdata)
	);
	spv_mem #(.WIDTH(8), .DEPTH(DATA_DEPTH), .AW(DATA_AW)) u_data (
		.clk_i(clk_i), .we_i(data_we), .addr_i(data_addr), .wdata_i(data_wdata),
		.rdata_o(data_rdata)
	);

	// ----------------------------------------
	// Read word selection
	// ----------------------------------------
	wire [13:0] cfg_word = (pc_reg == spv_pkg::DEVICE_CONFIG_ADDR) ? config_reg
		: (NEWER_VARIANT && pc_reg == spv_pkg::DEVICE_IDENTITY_ADDR)
			? {DEVICE_CODE, REVISION_CODE}
		: (cfg_slot < 4'h4) ? id_loc_reg[cfg_slot[1:0]] : spv_pkg::ZERO_WORD;
	wire [13:0] prog_word = protected_cp ? spv_pkg::ZERO_WORD : prog_rdata;
	wire [7:0] data_byte = protected_dp ? (ROM_VARIANT ? spv_pkg::ERASED_BYTE : 8'h00)
		: data_rdata;
	wire [13:0] read_word = is_cmd(cmd_reg, spv_pkg::CMD_READ_DATA)
		? {6'h00, data_byte}
		: (in_config && cfg_slot < 4'(spv_pkg::CONFIG_SLOTS / 2)) ? cfg_word : prog_word;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Also true at zero: a count that ran out early must not strand the sequencer
	// in busy with no way back
	wire timer_done = (timer_reg <= 32'h0000_0001);
	// Commands arriving while busy are not decoded at all
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			spv_pkg::ST_IDLE: if (mode_on) state_next = spv_pkg::ST_CMD;
			spv_pkg::ST_CMD: if (last_cmd_bit) begin
				if (cmd_has_frame) state_next = spv_pkg::ST_FRAME;
				else if ((begin_erase || begin_only)
					&& !((bulk_prog_reg || bulk_data_reg) && bulk_refused))
					state_next = spv_pkg::ST_BUSY;
			end
			spv_pkg::ST_GAP: state_next = spv_pkg::ST_CMD;
			spv_pkg::ST_FRAME: if (frame_end) state_next = spv_pkg::ST_CMD;
			spv_pkg::ST_BUSY: if (timer_done && !wiping_reg) state_next = spv_pkg::ST_CMD;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !mode_on) begin
			state_reg <= spv_pkg::ST_IDLE;
			cmd_cnt_reg <= 3'h0;
			cmd_reg <= 6'h00;
			edge_cnt_reg <= 5'h00;
			shift_reg <= 16'h0000;
			pc_reg <= spv_pkg::ZERO_WORD;
			latch_reg <= spv_pkg::ERASED_WORD;
			bulk_prog_reg <= 1'b0;
			bulk_data_reg <= 1'b0;
			toggle1_reg <= 1'b0;
			clear_armed_reg <= 1'b0;
			timer_reg <= 32'h0000_0000;
			pend_reg <= 1'b0;
			pend_data_reg <= 1'b0;
			load_data_reg <= 1'b0;
			wiping_reg <= 1'b0;
			wipe_prog_reg <= 1'b0;
			wipe_data_reg <= 1'b0;
			wipe_reg <= '0;
			prog_data_pin_o <= 1'b0;
			prog_data_pin_oe_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			pend_reg <= 1'b0;
			if (state_reg == spv_pkg::ST_CMD && fall) begin
				cmd_reg <= cmd_full;
				cmd_cnt_reg <= last_cmd_bit ? 3'h0 : cmd_cnt_reg + 3'h1;
			end
			if (last_cmd_bit) begin
				edge_cnt_reg <= 5'h00;
				if (is_cmd(cmd_full, spv_pkg::CMD_LOAD_CONFIG)) pc_reg <= spv_pkg::CONFIG_BASE;
				if (is_cmd(cmd_full, spv_pkg::CMD_INCREMENT))
					pc_reg <= {pc_reg[13], pc_reg[12:0] + 13'h0001};
				if (is_cmd(cmd_full, spv_pkg::CMD_BULK_PROG)) bulk_prog_reg <= 1'b1;
				if (is_cmd(cmd_full, spv_pkg::CMD_BULK_DATA)) bulk_data_reg <= 1'b1;
				// By the begin command cmd_reg already holds the begin code itself
				if (is_load) load_data_reg <= is_cmd(cmd_full, spv_pkg::CMD_LOAD_DATA);
				// Commands 1 then 7 arm the protection clear on the configuration word
				toggle1_reg <= (cmd_full == 6'h01);
				if (cmd_full == 6'h07 && toggle1_reg && pc_reg == spv_pkg::DEVICE_CONFIG_ADDR)
					clear_armed_reg <= 1'b1;
				if (begin_erase || begin_only) begin
					bulk_prog_reg <= 1'b0;
					bulk_data_reg <= 1'b0;
					if (bulk_prog_reg || bulk_data_reg || clear_armed_reg) begin
						if (!bulk_refused) begin
							wiping_reg <= 1'b1;
							wipe_reg <= '0;
							wipe_prog_reg <= bulk_prog_reg || clear_armed_reg;
							wipe_data_reg <= bulk_data_reg || clear_armed_reg;
							timer_reg <= 32'(BULK_CYCLES);
						end
					end else begin
						pend_reg <= !in_config;
						pend_data_reg <= load_data_reg;
						timer_reg <= begin_only ? 32'(WRITE_CYCLES) : 32'(ERASE_WRITE_CYCLES);
					end
				end
			end
			if (state_reg == spv_pkg::ST_BUSY && timer_reg != 32'h0000_0000)
				timer_reg <= timer_reg - 32'h0000_0001;
			if (wiping_reg) begin
				wipe_reg <= wipe_reg + (PROG_AW+1)'(1);
				if (wipe_reg == (PROG_AW+1)'(PROG_DEPTH - 1)) begin
					wiping_reg <= 1'b0;
					clear_armed_reg <= 1'b0;
				end
			end
			if (state_reg == spv_pkg::ST_FRAME) begin
				if (rise) begin
					edge_cnt_reg <= edge_cnt_reg + 5'h01;
					if (is_read && edge_cnt_reg == 5'h01) begin
						prog_data_pin_oe_o <= 1'b1;
						prog_data_pin_o <= read_word[0];
						shift_reg <= {3'h0, read_word[13:1]};
					end else if (is_read && edge_cnt_reg > 5'h01
						&& edge_cnt_reg < spv_pkg::DATA_LAST_EDGE) begin
						prog_data_pin_o <= shift_reg[0];
						shift_reg <= {1'b0, shift_reg[15:1]};
					end else if (edge_cnt_reg == spv_pkg::DATA_LAST_EDGE) begin
						prog_data_pin_o <= 1'b0; // Stop bit
					end
				end
				if (fall && !is_read) shift_reg <= {din, shift_reg[15:1]};
				if (frame_end) begin
					prog_data_pin_oe_o <= 1'b0;
					if (!is_read) latch_reg <= shift_reg[15:2];
				end
			end
		end
	end

	// ----------------------------------------
	// Configuration space: ID locations and configuration word
	// ----------------------------------------
	logic cfg_pend_reg;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			config_reg <= spv_pkg::ERASED_WORD;
			for (int i = 0; i < 4; i++) id_loc_reg[i] <= spv_pkg::ERASED_WORD;
			cfg_pend_reg <= 1'b0;
		end else begin
			cfg_pend_reg <= last_cmd_bit && (begin_erase || begin_only) && in_config
				&& !bulk_prog_reg && !bulk_data_reg && !clear_armed_reg;
			if (cfg_pend_reg && !ROM_VARIANT) begin
				// Still writable while protected
				if (pc_reg == spv_pkg::DEVICE_CONFIG_ADDR) config_reg <= latch_reg;
				else if (cfg_slot < 4'h4) id_loc_reg[cfg_slot[1:0]] <= latch_reg;
			end
			if (wiping_reg && wipe_prog_reg && in_config && wipe_reg == '0)
				for (int i = 0; i < 4; i++) id_loc_reg[i] <= spv_pkg::ERASED_WORD;
			// Clearing protection rewrites the word with the loaded ones
			if (wiping_reg && clear_armed_reg && wipe_reg == '0 && !ROM_VARIANT)
				config_reg <= latch_reg;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
			device_config_word_o <= spv_pkg::ERASED_WORD;
			config_view_o <= '0;
		end else begin
			busy_o <= (state_reg == spv_pkg::ST_BUSY);
			device_config_word_o <= config_reg;
			config_view_o.osc <= config_reg[spv_pkg::OSC_LSB +: 2];
			config_view_o.wdt_en <= config_reg[spv_pkg::WDT_BIT];
			config_view_o.pwrt_en_n <= config_reg[spv_pkg::PWRT_BIT];
			config_view_o.code_protected <= protected_cp;
			config_view_o.data_protected <= protected_dp;
		end
	end
endmodule

// *** tb/spv_programmer.sv ***
// Behavioural programmer: makes the link clock and drives the data line.
// Assumes the engine drives the line only while its output enable is high.
`timescale 1ns/100ps
module spv_programmer (
	input wire logic dut_d_i,
	input wire logic dut_oe_i,
	output logic pclk_o,
	output logic line_o
);
	logic drv_d = 1'b0;
	logic drv_oe = 1'b1;
	// Released line shows the inverse of our last bit, so stale data never reads right
	assign line_o = dut_oe_i ? dut_d_i : (drv_oe ? drv_d : ~drv_d);
	initial pclk_o = 1'b0;
	// ------
	// Link cycles
	// ------
	// Data set at the rise, read back just before the next rise
	task automatic tick(input logic d, output logic q);
		pclk_o = 1'b1;
		drv_d = d;
		#100;
		pclk_o = 1'b0;
		#100;
		q = line_o;
	endtask
	// Odd gap keeps the link out of step with clk_i
	task automatic cmd(input logic [5:0] c);
		logic q;
		#1000.3;
		for (int i = 0; i < 6; i++) begin
			tick(c[i], q);
		end
	endtask
	task automatic frame(input logic [15:0] v, output logic [15:0] q);
		#1000.3;
		for (int i = 0; i < 16; i++) begin
			tick(v[i], q[i]);
		end
	endtask
	task automatic load(input logic [5:0] c, input logic [13:0] wd);
		logic [15:0] q;
		cmd(c);
		frame({1'b0, wd, 1'b0}, q);
	endtask
	task automatic read(input logic [5:0] c, output logic [13:0] wd);
		logic [15:0] q;
		cmd(c);
		drv_oe = 1'b0;
		frame(16'h0000, q);
		drv_oe = 1'b1;
		wd = q[14:1];
	endtask
endmodule

// *** tb/spv_chk.sv ***
// Port checks of the program/verify engine, bound into its top module.
// Assumes each programmer clock phase spans several clk_i cycles.
`timescale 1ns/100ps
module spv_chk #(
	parameter int ERASE_WRITE_CYCLES = 20,
	parameter int WRITE_CYCLES = 10,
	parameter int BULK_CYCLES = 40
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic prog_clock_pin_i,
	input wire logic prog_data_pin_o,
	input wire logic prog_data_pin_oe_o,
	input wire logic busy_o,
	input wire logic [13:0] device_config_word_o,
	input wire spv_pkg::config_view_s config_view_o
);
	logic pclk_reg;
	logic [4:0] rise_cnt_reg;
	logic [15:0] busy_cnt_reg;
	logic [1:0] up_reg;
	wire logic pclk_rise = prog_clock_pin_i & ~pclk_reg;
	wire logic [13:0] cfg = device_config_word_o;
	wire logic cp_exp = (cfg & spv_pkg::CP_MASK) == 14'h0000;
	always_ff @(posedge clk_i) begin
		pclk_reg <= prog_clock_pin_i;
		rise_cnt_reg <= prog_data_pin_oe_o ? rise_cnt_reg + {4'h0, pclk_rise} : 5'h00;
		busy_cnt_reg <= busy_o ? busy_cnt_reg + 16'h0001 : 16'h0000;
		up_reg <= rst_n_i ? up_reg + {1'b0, up_reg != 2'h3} : 2'h0;
	end
	// ------
	// Properties
	// ------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_oe_on_rise; $rose(prog_data_pin_oe_o) |-> $past(prog_clock_pin_i); endproperty
	a_oe_on_rise: assert property (p_oe_on_rise) else $error("oe rose off a clock high");
	property p_oe_off_fall; $fell(prog_data_pin_oe_o) |-> !$past(prog_clock_pin_i); endproperty
	a_oe_off_fall: assert property (p_oe_off_fall) else $error("oe fell off a clock low");
	property p_oe_span; $fell(prog_data_pin_oe_o) |-> rise_cnt_reg == 5'h0e; endproperty
	a_oe_span: assert property (p_oe_span) else $error("oe span not 14 rises");
	property p_bit_on_rise;
		prog_data_pin_oe_o && $past(prog_data_pin_oe_o) && $changed(prog_data_pin_o)
			|-> $past(prog_clock_pin_i);
	endproperty
	a_bit_on_rise: assert property (p_bit_on_rise) else $error("data moved off a rise");
	property p_busy_min; $rose(busy_o) |-> busy_o [*8]; endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy too short");
	property p_busy_span;
		$fell(busy_o) |-> busy_cnt_reg >= WRITE_CYCLES - 1 && busy_cnt_reg <= BULK_CYCLES + 2;
	endproperty
	a_busy_span: assert property (p_busy_span) else $error("busy length off");
	property p_quiet_busy; busy_o |-> !prog_data_pin_oe_o; endproperty
	a_quiet_busy: assert property (p_quiet_busy) else $error("line driven while busy");
	property p_view;
		up_reg == 2'h3 && $past(cfg, 2) == cfg |-> config_view_o.osc == cfg[1:0]
			&& config_view_o.wdt_en == cfg[2] && config_view_o.pwrt_en_n == cfg[3]
			&& config_view_o.code_protected == cp_exp;
	endproperty
	a_view: assert property (p_view) else $error("config view off");
	c_timed: cover property (busy_cnt_reg == ERASE_WRITE_CYCLES);
	c_read: cover property ($fell(prog_data_pin_oe_o));
	c_prot: cover property ($rose(config_view_o.code_protected));
endmodule
bind serial_program_verify_engine spv_chk #(.ERASE_WRITE_CYCLES(ERASE_WRITE_CYCLES),
	.WRITE_CYCLES(WRITE_CYCLES), .BULK_CYCLES(BULK_CYCLES)) chk_u (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .prog_clock_pin_i(prog_clock_pin_i),
	.prog_data_pin_o(prog_data_pin_o), .prog_data_pin_oe_o(prog_data_pin_oe_o),
	.busy_o(busy_o), .device_config_word_o(device_config_word_o),
	.config_view_o(config_view_o));

// *** tb/testbench.sv ***
// Bench top: engine with bound checks, programmer model and scenario tasks.
// Assumes shortened self-timed cycles; programmer clock period 200 ns.
`timescale 1ns/100ps
module testbench;
	localparam logic [8:0] DEV = 9'h0a5;  // Arbitrary value
	localparam logic [4:0] REV = 5'h01;  // Arbitrary value
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic mode = 1'b0;
	logic pclk, line, dout, doe, busy;
	logic [13:0] cfg, w;
	spv_pkg::config_view_s view;
	int err_total = 0;
	int n_checks = 0;
	int cyc_cnt = 0;
	always #12.5 clk = ~clk;
	spv_programmer prog_u (.dut_d_i(dout), .dut_oe_i(doe), .pclk_o(pclk), .line_o(line));
	// Bulk count must outlast the 1024-word wipe; identity codes stay at their defaults
	serial_program_verify_engine #(.ERASE_WRITE_CYCLES(20), .WRITE_CYCLES(10),
		.BULK_CYCLES(1100)) dut_u (
		.clk_i(clk), .rst_n_i(rst_n), .high_voltage_mode_select_i(mode),
		.prog_clock_pin_i(pclk), .prog_data_pin_i(line), .prog_data_pin_o(dout),
		.prog_data_pin_oe_o(doe), .busy_o(busy), .device_config_word_o(cfg),
		.config_view_o(view));
	task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		if (err_total == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			err_total++;
			report_and_stop();
		end
	end
	// No completion signal on the link, so wait out busy with a bound
	task automatic begin_wait(input logic [5:0] c, input bit timed);
		int n;
		n = 0;
		prog_u.cmd(c);
		while (busy !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (timed) check("busy raised", 14'h0001, {13'h0000, busy});
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check("busy dropped", 14'h0000, {13'h0000, busy});
	endtask
	task automatic reenter();
		@(posedge clk);
		mode <= 1'b0;
		repeat (10) @(posedge clk);
		mode <= 1'b1;
		repeat (10) @(posedge clk);
	endtask
	// ------
	// Scenarios
	// ------
	task automatic t_prog();
		prog_u.load(6'h02, 14'h3fff);
		prog_u.cmd(6'h09);
		begin_wait(6'h08, 1'b1);
		prog_u.read(6'h04, w);
		check("bulk erased word", 14'h3fff, w);
		prog_u.load(6'h02, 14'h2a5c);
		begin_wait(6'h08, 1'b1);
		prog_u.read(6'h34, w);
		check("written word", 14'h2a5c, w);
		prog_u.cmd(6'h06);
		prog_u.read(6'h04, w);
		check("next word", 14'h3fff, w);
		prog_u.load(6'h02, 14'h15a3);
		begin_wait(6'h18, 1'b1);
		prog_u.read(6'h04, w);
		check("program-only word", 14'h15a3, w);
	endtask
	task automatic t_data();
		prog_u.load(6'h03, 14'h3fff);
		prog_u.cmd(6'h0b);
		begin_wait(6'h08, 1'b1);
		prog_u.read(6'h05, w);
		check("erased byte", 14'h00ff, {6'h00, w[7:0]});
		prog_u.load(6'h03, 14'h3fc5);
		begin_wait(6'h08, 1'b1);
		prog_u.read(6'h05, w);
		check("data byte", 14'h00c5, {6'h00, w[7:0]});
	endtask
	task automatic t_config();
		prog_u.load(6'h00, 14'h3ff5);
		begin_wait(6'h08, 1'b0);
		prog_u.read(6'h04, w);
		check("identity slot", 14'h3ff5, w);
		repeat (6) prog_u.cmd(6'h06);
		prog_u.read(6'h04, w);
		check("device identity", {DEV, REV}, w);
		prog_u.cmd(6'h06);
		for (int i = 0; i < 4; i++) begin
			prog_u.load(6'h02, {10'h3ff, i[1:0], i[1:0]});
			begin_wait(6'h08, 1'b0);
			check("config word", {10'h3ff, i[1:0], i[1:0]}, cfg);
			check("view", {8'h00, i[1:0], i[0], i[1], 2'b00}, {8'h00, view});
		end
		prog_u.load(6'h02, 14'h0006);
		begin_wait(6'h08, 1'b0);
		check("protected view", 14'h002b, {8'h00, view});
		prog_u.read(6'h04, w);
		check("config readback", 14'h0006, w);
	endtask
	task automatic t_protect();
		reenter();
		prog_u.read(6'h04, w);
		check("protected word", 14'h0000, w);
		prog_u.load(6'h02, 14'h3fff);
		prog_u.cmd(6'h09);
		prog_u.cmd(6'h08);
		repeat (8) @(posedge clk);
		check("refused bulk busy", 14'h0000, {13'h0000, busy});
		prog_u.load(6'h00, 14'h3fff);
		repeat (7) prog_u.cmd(6'h06);
		prog_u.cmd(6'h01);
		prog_u.cmd(6'h07);
		begin_wait(6'h08, 1'b0);
		prog_u.cmd(6'h01);
		prog_u.cmd(6'h07);
		reenter();
		prog_u.read(6'h04, w);
		check("cleared word", 14'h3fff, w);
		prog_u.read(6'h05, w);
		check("cleared byte", 14'h00ff, {6'h00, w[7:0]});
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		mode <= 1'b1;
		repeat (8) @(posedge clk);
		check("reset config", 14'h3fff, cfg);
		check("reset oe", 14'h0000, {13'h0000, doe});
		t_prog();
		t_data();
		t_config();
		t_protect();
		report_and_stop();
	end
endmodule
